// file: bench/dpe_board_model.sv
// Purpose: board logic beside the drive port
// Assumes: levels set by the bench
// Notes: released data lines toggle, never hold
`timescale 1ns/1ps
`default_nettype none
module dpe_board_model (
   input wire logic core_clk,
   input wire logic enWant,
   input wire logic dataOeN,
   input wire logic [15:0] pinData,
   output logic drivePortEnableIn,
   output logic [15:0] driveDataLinesIn
);
   logic [15:0] junk = 16'h5a5a;
   always @(posedge core_clk) junk <= ~junk;
   assign drivePortEnableIn = enWant;
   assign driveDataLinesIn = dataOeN ? junk : pinData;
endmodule : dpe_board_model
`default_nettype wire

// file: bench/dpe_power_ctrl_checker.sv
// Purpose: port assertions of the power control block
// Assumes: bound to dpe_power_ctrl
// Notes: pull-up and low-power flags lag the state by one cycle
`timescale 1ns/1ps
`default_nettype none
module dpe_power_ctrl_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire dpe_pkg::dpe_drive_oe_t drivePinsOeN,
   input wire logic busPullupAttach,
   input wire logic lowPowerMode,
   input wire logic driveFsmHalt,
   input wire dpe_pkg::dpe_pwr_state_t powerState
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_halt; driveFsmHalt == drivePinsOeN.ctrlOeN; endproperty
   a_halt: assert property (p_halt) else $error("halt vs oe");
   property p_oe; drivePinsOeN inside {3'h7, 3'h3, 3'h1, 3'h0}; endproperty
   a_oe: assert property (p_oe) else $error("oe order");
   property p_pull; busPullupAttach |-> $past(powerState) != dpe_pkg::ST_LOW_POWER; endproperty
   a_pull: assert property (p_pull) else $error("pull-up in low power");
   property p_lpm;
      lowPowerMode == ($past(powerState) inside {dpe_pkg::ST_LOW_POWER, dpe_pkg::ST_SUSPEND});
   endproperty
   a_lpm: assert property (p_lpm) else $error("low power flag");
   property p_fall;
      $past(powerState) == dpe_pkg::ST_RUN && powerState == dpe_pkg::ST_LOW_POWER
         |=> driveFsmHalt && lowPowerMode && !busPullupAttach;
   endproperty
   a_fall: assert property (p_fall) else $error("fall walk");
   property p_wake;
      $rose(powerState == dpe_pkg::ST_BRIEF_WAKE) |-> ##[15:17] powerState == dpe_pkg::ST_SUSPEND;
   endproperty
   a_wake: assert property (p_wake) else $error("wake length");
   property p_exit;
      powerState == dpe_pkg::ST_BRIEF_WAKE
         |=> powerState inside {dpe_pkg::ST_BRIEF_WAKE, dpe_pkg::ST_SUSPEND};
   endproperty
   a_exit: assert property (p_exit) else $error("wake exit");
   property p_rise;
      $past(powerState) == dpe_pkg::ST_LOW_POWER && powerState == dpe_pkg::ST_RUN
         |=> !lowPowerMode ##[0:2] drivePinsOeN.addrOeN;
   endproperty
   a_rise: assert property (p_rise) else $error("restart");
   property p_lp_float;
      powerState == dpe_pkg::ST_LOW_POWER |-> ##2 drivePinsOeN.addrOeN;
   endproperty
   a_lp_float: assert property (p_lp_float) else $error("address driven in low power");
endmodule : dpe_power_ctrl_checker
bind dpe_power_ctrl dpe_power_ctrl_checker i_dpe_power_ctrl_checker (.core_clk(core_clk),
   .rst(rst), .drivePinsOeN(drivePinsOeN), .busPullupAttach(busPullupAttach),
   .lowPowerMode(lowPowerMode), .driveFsmHalt(driveFsmHalt), .powerState(powerState));
`default_nettype wire

// file: bench/drive_port_enable_power_control_tb.sv
// Purpose: self-checking bench of the power control block
// Assumes: poll 20, start delay 10 cycles
// Notes: setIn changes enable and bus power just after a poll
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) \
   n_checks++; \
   if ((g) !== (e)) \
   begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
   end
module drive_port_enable_power_control_tb;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic enWant = 1'h1;
   logic pwr = 1'h1;
   logic susp = 1'h0;
   logic hold = 1'h0;
   logic mfg = 1'h0;
   logic [15:0] dCap;
   dpe_pkg::dpe_drive_t req = {9'h0d5, 16'hc3a5, 1'h1};
   dpe_pkg::dpe_drive_t pins;
   dpe_pkg::dpe_drive_oe_t oe;
   dpe_pkg::dpe_pwr_state_t st;
   logic en, pull, lowPwr, halt;
   logic [15:0] dIn;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int ticks = 0;
   initial forever #2 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
   always @(posedge core_clk)
   begin
      ticks <= ticks + 1;
      if (ticks == 3000)
      begin
         fail_count++;
         end_sim();
      end
   end
   dpe_power_ctrl #(.POLL_CYCLES(20), .START_DELAY_CYCLES(10)) i_dpe_power_ctrl (
      .core_clk(core_clk), .rst(rst), .drivePortEnableIn(en), .busPowerDetectIn(pwr),
      .mfgTestMode(mfg), .usbSuspend(susp), .otherLowPowerHold(hold), .driveReq(req),
      .driveDataLinesIn(dIn), .drivePins(pins), .drivePinsOeN(oe), .driveDataCaptured(dCap),
      .busPullupAttach(pull), .lowPowerMode(lowPwr), .driveFsmHalt(halt), .powerState(st));
   dpe_board_model i_dpe_board_model (.core_clk(core_clk), .enWant(enWant),
      .dataOeN(oe.dataOeN), .pinData(pins.driveDataLines), .drivePortEnableIn(en),
      .driveDataLinesIn(dIn));
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : cycles
   // lands a change one edge after a poll, so it is seen at the next poll
   task automatic waitPoll;
      do @(negedge core_clk); while (cyc % 20 != 1);
      @(posedge core_clk);
   endtask : waitPoll
   task automatic setIn(input logic e, input logic p);
      waitPoll();
      enWant <= e;
      pwr <= p;
      cycles(24);
   endtask : setIn
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic tStart;
      cycles(4);
      `CK("halt", 1'h0, halt)
      `CK("addr", 3'h7, pins.driveRegAddr)
      `CK("rd strobe", 1'h1, pins.driveReadStrobeN)
      `CK("pullup", 1'h1, pull)
      cycles(14);
      `CK("addr", 3'h2, pins.driveRegAddr)
      `CK("rd strobe", 1'h0, pins.driveReadStrobeN)
      `CK("oe", 3'h0, oe)
      `CK("data", 16'hc3a5, dCap)
   endtask : tStart
   task automatic tGlitch;
      waitPoll();
      enWant <= 1'h0;
      repeat (5) @(posedge core_clk);
      enWant <= 1'h1;
      cycles(25);
      `CK("st", dpe_pkg::ST_RUN, st)
   endtask : tGlitch
   // test mode freezes the enable sample while bus power is still polled
   task automatic tMfg;
      @(posedge core_clk) mfg <= 1'h1;
      setIn(1'h0, 1'h0);
      `CK("st", dpe_pkg::ST_RUN, st)
      `CK("halt", 1'h0, halt)
      `CK("pullup", 1'h0, pull)
      setIn(1'h1, 1'h1);
      @(posedge core_clk) mfg <= 1'h0;
      `CK("pullup", 1'h1, pull)
   endtask : tMfg
   task automatic tFall;
      setIn(1'h0, 1'h1);
      `CK("st", dpe_pkg::ST_LOW_POWER, st)
      `CK("oe", 3'h7, oe)
      @(posedge core_clk) hold <= 1'h1;
      setIn(1'h1, 1'h1);
      `CK("st", dpe_pkg::ST_LOW_POWER, st)
      `CK("addr oe", 1'h1, oe.addrOeN)
      setIn(1'h0, 1'h1);
      @(posedge core_clk) hold <= 1'h0;
      setIn(1'h1, 1'h1);
      `CK("st", dpe_pkg::ST_RUN, st)
      `CK("addr oe", 1'h1, oe.addrOeN)
      cycles(12);
      `CK("addr oe", 1'h0, oe.addrOeN)
   endtask : tFall
   task automatic tSusp;
      @(posedge core_clk) susp <= 1'h1;
      cycles(3);
      setIn(1'h0, 1'h1);
      `CK("low power", 1'h0, lowPwr)
      `CK("halt", 1'h1, halt)
      cycles(20);
      `CK("st", dpe_pkg::ST_SUSPEND, st)
      setIn(1'h1, 1'h1);
      `CK("halt", 1'h0, halt)
      cycles(20);
      `CK("low power", 1'h1, lowPwr)
      @(posedge core_clk) susp <= 1'h0;
      cycles(3);
   endtask : tSusp
   task automatic tPwr;
      setIn(1'h1, 1'h0);
      `CK("pullup", 1'h0, pull)
      setIn(1'h1, 1'h1);
      `CK("pullup", 1'h1, pull)
   endtask : tPwr
   task automatic tReset;
      setIn(1'h0, 1'h1);
      @(posedge core_clk) rst <= 1'h1;
      cycles(1);
      `CK("st", dpe_pkg::ST_RUN, st)
      `CK("oe", 3'h7, oe)
      @(posedge core_clk) enWant <= 1'h1;
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      tStart();
   endtask : tReset
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst <= 1'h0;
      tStart();
      tGlitch();
      tMfg();
      tFall();
      tSusp();
      tPwr();
      tReset();
      end_sim();
   end
endmodule : drive_port_enable_power_control_tb
`default_nettype wire

// file: design/dpe_pkg.sv
// Purpose: shared constants and carriers of the drive port enable and power control block
// Assumes: core clock of 250 MHz
// Notes: long counts are overridden by top-level parameters in simulation
package dpe_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned POLL_MS = 20;
   localparam int unsigned POLL_PER_SEC = 50;
   localparam int unsigned START_DELAY_MS = 2;
   localparam int unsigned RESET_HOLD_MS = 10;
   // cycle counts derived from the printed times as milliseconds times 1000 times the clock in MHz
   localparam int unsigned POLL_CYCLES = POLL_MS * 1000 * CLK_MHZ;
   localparam int unsigned START_DELAY_CYCLES = START_DELAY_MS * 1000 * CLK_MHZ;
   localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * CLK_MHZ;
   // length of the short wake-up while suspended
   localparam int unsigned WAKE_CYCLES = 16;
   localparam logic [2:0] IDLE_REG_ADDR = 3'h7;
   localparam logic [1:0] IDLE_CHIP_SEL_N = 2'h3;
   localparam logic IDLE_STROBE_N = 1'h1;

   typedef struct packed {
      logic driveReadStrobeN;
      logic driveWriteStrobeN;
      logic driveDmaAckN;
      logic [2:0] driveRegAddr;
      logic [1:0] driveChipSelN;
      logic driveResetOutN;
      logic [15:0] driveDataLines;
      logic dataDrive;
   } dpe_drive_t;

   typedef struct packed {
      logic ctrlOeN;
      logic addrOeN;
      logic dataOeN;
   } dpe_drive_oe_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_LOW_POWER = 2'b01,
      ST_SUSPEND = 2'b10,
      ST_BRIEF_WAKE = 2'b11
   } dpe_pwr_state_t;
endpackage : dpe_pkg

// file: design/dpe_power_ctrl.sv
// Purpose: polls drive port enable and bus power, gates the drive pins, sequences low power
// Assumes: inputs synchronous to core_clk; drive core supplies pin values in driveReq
// Notes: pin outputs are registered, so they follow driveReq one cycle late
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sample drive enable every poll period, except in test mode
// - low enable floats pins, halts drive logic
// - enable falls running: disconnect, low power
// - enable rises: restart and reconnect, unless otherLowPowerHold
// - fall in suspend: brief wake, float pins
// - rise in suspend: brief wake, drive pins
// - sample bus power at start, each period
// - bus power high attaches pull-up
// - bus power low releases pull-up
// - reset reinitialises all logic
// - address, selects, data wait startup delay
module dpe_power_ctrl #(
   parameter int unsigned POLL_CYCLES = dpe_pkg::POLL_CYCLES,
   parameter int unsigned START_DELAY_CYCLES = dpe_pkg::START_DELAY_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic drivePortEnableIn,
   input wire logic busPowerDetectIn,
   input wire logic mfgTestMode,
   input wire logic usbSuspend,
   input wire logic otherLowPowerHold,
   input wire dpe_pkg::dpe_drive_t driveReq,
   input wire logic [15:0] driveDataLinesIn,
   output var dpe_pkg::dpe_drive_t drivePins,
   output var dpe_pkg::dpe_drive_oe_t drivePinsOeN,
   output logic [15:0] driveDataCaptured,
   output logic busPullupAttach,
   output logic lowPowerMode,
   output logic driveFsmHalt,
   output var dpe_pkg::dpe_pwr_state_t powerState
);
   // true when the new sample differs from the last and lands on level lvl
   function automatic logic changedTo(input logic prev, input logic now, input logic lvl);
      changedTo = (prev != now) && (now == lvl);
   endfunction : changedTo

   logic pollTick;
   logic started;
   logic enSampled;
   logic vbusSampled;
   logic enRose;
   logic enFell;
   logic pinsEnabled;
   logic restartDelay;
   logic delayDone;
   logic [31:0] delayCount;
   logic [4:0] wakeCount;
   logic pollNow;

   dpe_tick #(
      .PERIOD(POLL_CYCLES)
   ) i_dpe_tick (
      .core_clk(core_clk),
      .rst(rst),
      .tick(pollTick)
   );

   // first cycle after reset takes the start-up sample
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         started <= 1'b0;
      end
      else
      begin
         started <= 1'b1;
      end
   end

   // the enable is frozen in test mode, so its pins stay under test control
   assign pollNow = !mfgTestMode && (pollTick || !started);

   // no change event on the start-up sample: there is nothing to compare it with
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         enSampled <= 1'b0;
         enRose <= 1'b0;
         enFell <= 1'b0;
      end
      else
      begin
         enRose <= 1'b0;
         enFell <= 1'b0;
         if (pollNow)
         begin
            enSampled <= drivePortEnableIn;
            enRose <= started && changedTo(enSampled, drivePortEnableIn, 1'b1);
            enFell <= started && changedTo(enSampled, drivePortEnableIn, 1'b0);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         vbusSampled <= 1'b0;
      end
      else if (pollTick || !started)
      begin
         vbusSampled <= busPowerDetectIn;
      end
   end

   // power state sequencing
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         powerState <= dpe_pkg::ST_RUN;
         wakeCount <= 5'h0;
         restartDelay <= 1'b0;
      end
      else
      begin
         restartDelay <= 1'b0;
         unique case (powerState)
            dpe_pkg::ST_RUN:
            begin
               if (enFell)
               begin
                  powerState <= dpe_pkg::ST_LOW_POWER;
               end
               else if (usbSuspend)
               begin
                  powerState <= dpe_pkg::ST_SUSPEND;
               end
            end
            dpe_pkg::ST_LOW_POWER:
            begin
               if (enRose && !otherLowPowerHold)
               begin
                  powerState <= dpe_pkg::ST_RUN;
                  restartDelay <= 1'b1;
               end
            end
            dpe_pkg::ST_SUSPEND:
            begin
               if (enRose || enFell)
               begin
                  powerState <= dpe_pkg::ST_BRIEF_WAKE;
                  wakeCount <= 5'(dpe_pkg::WAKE_CYCLES - 1);
               end
               else if (!usbSuspend)
               begin
                  powerState <= dpe_pkg::ST_RUN;
               end
            end
            dpe_pkg::ST_BRIEF_WAKE:
            begin
               if (wakeCount == 5'h0)
               begin
                  powerState <= dpe_pkg::ST_SUSPEND;
               end
               else
               begin
                  wakeCount <= wakeCount - 5'h1;
               end
            end
         endcase
      end
   end

   // pin drive follows the sample except while asleep; the brief wake applies it
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pinsEnabled <= 1'b0;
      end
      else if (powerState != dpe_pkg::ST_SUSPEND)
      begin
         pinsEnabled <= enSampled;
      end
   end

   // start-up delay, rerun on the return from low power to the post-reset state
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         delayCount <= 32'h0;
         delayDone <= 1'b0;
      end
      else if (restartDelay || (powerState == dpe_pkg::ST_LOW_POWER))
      begin
         // held at zero in low power, so the return floats address and data like a reset
         delayCount <= 32'h0;
         delayDone <= 1'b0;
      end
      else if (!delayDone)
      begin
         delayCount <= delayCount + 32'h1;
         delayDone <= (delayCount == 32'(START_DELAY_CYCLES - 1));
      end
   end

   // registered pin values; strobes idle high until the delay has run
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         drivePins <= '{driveReadStrobeN: dpe_pkg::IDLE_STROBE_N,
                        driveWriteStrobeN: dpe_pkg::IDLE_STROBE_N,
                        driveDmaAckN: dpe_pkg::IDLE_STROBE_N,
                        driveRegAddr: dpe_pkg::IDLE_REG_ADDR,
                        driveChipSelN: dpe_pkg::IDLE_CHIP_SEL_N,
                        driveResetOutN: 1'b1,
                        driveDataLines: 16'h0,
                        dataDrive: 1'b0};
      end
      else
      begin
         drivePins <= driveReq;
         if (!delayDone)
         begin
            drivePins.driveReadStrobeN <= dpe_pkg::IDLE_STROBE_N;
            drivePins.driveWriteStrobeN <= dpe_pkg::IDLE_STROBE_N;
            drivePins.driveDmaAckN <= dpe_pkg::IDLE_STROBE_N;
            drivePins.driveRegAddr <= dpe_pkg::IDLE_REG_ADDR;
            drivePins.driveChipSelN <= dpe_pkg::IDLE_CHIP_SEL_N;
            drivePins.dataDrive <= 1'b0;
         end
      end
   end

   // enables low while driving
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         drivePinsOeN <= 3'h7;
      end
      else
      begin
         drivePinsOeN.ctrlOeN <= !pinsEnabled;
         drivePinsOeN.addrOeN <= !(pinsEnabled && delayDone);
         drivePinsOeN.dataOeN <= !(pinsEnabled && delayDone && driveReq.dataDrive);
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         driveDataCaptured <= 16'h0;
         driveFsmHalt <= 1'b1;
      end
      else
      begin
         driveDataCaptured <= driveDataLinesIn;
         driveFsmHalt <= !pinsEnabled;
      end
   end

   // pull-up also dropped in the low-power state that a falling enable enters from run
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busPullupAttach <= 1'b0;
         lowPowerMode <= 1'b0;
      end
      else
      begin
         busPullupAttach <= vbusSampled && (powerState != dpe_pkg::ST_LOW_POWER);
         lowPowerMode <= (powerState == dpe_pkg::ST_LOW_POWER) ||
                         (powerState == dpe_pkg::ST_SUSPEND);
      end
   end
endmodule : dpe_power_ctrl
`default_nettype wire

// file: design/dpe_tick.sv
// Purpose: free-running period tick
// Assumes: PERIOD of at least 2
// Notes: tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module dpe_tick #(
   parameter int unsigned PERIOD = 1000
) (
   input wire logic core_clk,
   input wire logic rst,
   output logic tick
);
   logic [31:0] count;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         count <= 32'h0;
         tick <= 1'b0;
      end
      else if (count == 32'(PERIOD - 1))
      begin
         count <= 32'h0;
         tick <= 1'b1;
      end
      else
      begin
         count <= count + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule : dpe_tick
`default_nettype wire
